// ### core/nbp_block_protect.sv
/*
  Block-protection and feature-option core of the serial flash: protect
  range decode, write guard, lockdown, locked-block refusal, auto next
  page timing and the training-pattern option.
  Assumes the link front end in nbp_link_rx, a write-guard pin arriving
  asynchronously, and i_rst asserted at power-up.
*/
// Contract
// [RULE_01] Power-up: three select bits set, flip, complement, pin lock cleared.
// [RULE_02] Pin lock set and guard pin low: bits 5..1 cannot be set.
// [RULE_03] Program or erase on a locked block does not start, busy stays 0.
// [RULE_04] Erase on a locked block sets the erase failure bit.
// [RULE_05] Program on a locked block sets the program failure bit.
// [RULE_06] Guard pin works only while four-lane enable is 0.
// [RULE_07] Decode selects to none, all, upper fractions, flipped, complemented, block 0.
// [RULE_08] Host changes protection with set-features at address A0h.
// [RULE_09] Freeze bit at 60h blocks later changes to protection bits.
// [RULE_10] Freeze clears only by power cycle, never by software.
// [RULE_11] Auto next page loads the following page in background.
// [RULE_12] Page read of the prefetched page takes the shortened time.
// [RULE_13] Page read of any other page takes the normal time.
// [RULE_14] Auto next page only with plain read mode and correction on.
// [RULE_15] Training bit set: pattern 00110100 on four lanes, last four dummies.
// [RULE_16] Training bit clear: no pattern during quad DTR dummies.
// [RULE_17] Host may tune per-lane capture in the pattern window.
// [RULE_18] Error correction enabled at power-up.
// [RULE_19] Feature reads return current protection, freeze and option bits.
// [RULE_20] Row of program or erase checked against lock range first.
`timescale 1ns/1ps
`default_nettype none
`include "nbp_regs.svh"

module nbp_block_protect #(
  parameter int unsigned ATC_NORMAL_CYC = `NBP_ATC_NORMAL_CYC,
  parameter int unsigned ATC_FAST_CYC = `NBP_ATC_FAST_CYC,
  parameter int unsigned PE_BUSY_CYC = `NBP_PE_BUSY_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  output logic [3:0] o_dq_rise,
  output logic [3:0] o_dq_fall,
  output logic o_dq_oe,
  output logic o_busy_flag_op,
  output logic o_prog_fail,
  output logic o_erase_fail,
  output logic o_fast_load,
  output logic [7:0] o_block_lock,
  output logic o_protect_freeze
);
  import nbp_pkg::*;

  // Busy counter is 12 bits wide
  if (ATC_NORMAL_CYC < 1 || ATC_NORMAL_CYC > 4095 || ATC_FAST_CYC < 1
      || ATC_FAST_CYC > 4095 || PE_BUSY_CYC < 1 || PE_BUSY_CYC > 4095) begin : g_bad_count
    $error("busy counts must lie in 1..4095");
  end

  localparam nbp_core_t CORE_RST = '{
    wp_sync: 3'h7,
    wp_n: 1'b1,
    lock: `NBP_LK_RST,
    cfg: `NBP_CFG_RST,
    op: NBP_IDLE,
    snap: '{lock: `NBP_LK_RST, frz: 8'h00, cfg: `NBP_CFG_RST, stat: 8'h00},
    default: '0
  };

  nbp_core_t s, next_s;
  logic link_tog;
  nbp_byte_t link_buf0;
  nbp_byte_t link_buf1;
  nbp_byte_t b;
  logic ev;
  logic guard;
  logic anp;
  logic [15:0] row;
  logic hit;
  logic fast_ok;
  logic exe_prog;
  logic exe_erase;
  logic exe_load;
  logic [7:0] wr_lock;

  // [RULE_07] locked range decode
  // Locked-range decode of one row against the block_lock value
  function automatic logic lock_hit(input logic [15:0] r, input logic [7:0] lk);
    logic [2:0] code;
    logic [16:0] sz;
    logic [16:0] rr;
    code = lk[`NBP_LK_SEL_2:`NBP_LK_SEL_0];
    sz = `NBP_FRAC_BASE << (code - 3'h1);
    rr = {1'b0, r};
    if (code == 3'h0) begin
      lock_hit = 1'b0;
    end else if (code == 3'h7) begin
      lock_hit = 1'b1;
    end else if (lk[`NBP_LK_COMPL] && code == 3'h6) begin
      lock_hit = r <= `NBP_BLOCK0_LAST;
    end else begin
      case ({lk[`NBP_LK_COMPL], lk[`NBP_LK_FLIP]})
        2'h0: lock_hit = rr >= `NBP_ROW_TOP - sz;
        2'h1: lock_hit = rr < sz;
        2'h2: lock_hit = rr < `NBP_ROW_TOP - sz;
        default: lock_hit = rr >= sz;
      endcase
    end
  endfunction

  // Link side runs on the serial clock
  nbp_link_rx u_link (
    .i_sck(i_sck),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_si(i_si),
    .i_snap(s.snap),
    .o_so(o_so),
    .o_so_oe(o_so_oe),
    .o_dq_rise(o_dq_rise),
    .o_dq_fall(o_dq_fall),
    .o_dq_oe(o_dq_oe),
    .o_tog(link_tog),
    .o_buf0(link_buf0),
    .o_buf1(link_buf1)
  );

  // Next core state
  always_comb begin
    next_s = s;
    ev = 1'b0;
    exe_prog = 1'b0;
    exe_erase = 1'b0;
    exe_load = 1'b0;
    b = s.tsync[2] ? link_buf1 : link_buf0;
    // [RULE_06] pin guard only in single-lane setting
    guard = s.lock[`NBP_LK_PIN_LOCK] && !s.wp_n && !s.cfg[`NBP_CFG_FOUR_LANE];
    // [RULE_14] auto next page needs plain read and correction
    anp = s.cfg[`NBP_CFG_AUTO_NEXT] && s.cfg[`NBP_CFG_PLAIN_READ] && s.cfg[`NBP_CFG_ECC];
    row = {s.row_hi, b.data};
    // [RULE_20] row checked before any array work
    hit = lock_hit(row, s.lock);
    fast_ok = anp && s.pf_valid && row == s.pf_row;
    wr_lock = b.data & `NBP_LK_WMASK;
    if (guard) begin
      // [RULE_02] guarded bits may fall but not rise
      wr_lock = (wr_lock & ~`NBP_LK_GUARD_MASK) | (wr_lock & s.lock & `NBP_LK_GUARD_MASK);
    end

    // Three-stage pin sync; a level counts once the last two agree
    next_s.wp_sync = {s.wp_sync[1:0], i_wp_n};
    if (s.wp_sync[2] == s.wp_sync[1]) begin
      next_s.wp_n = s.wp_sync[2];
    end

    // Byte toggle from the link; buffer named by the toggle is stable now
    next_s.tsync = {s.tsync[1:0], link_tog};
    if (s.tsync[2] == s.tsync[1] && s.tsync[2] != s.seen) begin
      ev = 1'b1;
      next_s.seen = s.tsync[2];
      case (b.idx)
        2'h0: next_s.opc = b.data;
        2'h1: next_s.fa = b.data;
        2'h2: begin
          next_s.row_hi = b.data;
          // [RULE_08] set-features write
          if (s.opc == `NBP_OP_SET_FEAT) begin
            case (s.fa)
              `NBP_FA_BLOCK_LOCK: begin
                // [RULE_09] frozen protection ignores writes
                if (!s.frz) begin
                  next_s.lock = wr_lock;
                end
              end
              `NBP_FA_LOCKDOWN: begin
                // [RULE_10] freeze only ever sets
                if (b.data[`NBP_FRZ_BIT]) begin
                  next_s.frz = 1'b1;
                end
              end
              `NBP_FA_CONFIG: next_s.cfg = b.data & `NBP_CFG_WMASK;
              default: next_s.cfg = s.cfg;
            endcase
          end
        end
        default: begin
          // Array commands act on the last row byte and only when idle
          next_s.opc = 8'h00;
          if (s.op == NBP_IDLE) begin
            case (s.opc)
              `NBP_OP_PROG_EXEC: begin
                exe_prog = 1'b1;
                if (hit) begin
                  // [RULE_03] [RULE_05] refused, failure flagged
                  next_s.pfail = 1'b1;
                end else begin
                  next_s.pfail = 1'b0;
                  next_s.op = NBP_PROG;
                  next_s.cnt = 12'(PE_BUSY_CYC);
                  next_s.busy_flag_op = 1'b1;
                  next_s.pf_valid = 1'b0;
                end
              end
              `NBP_OP_BLK_ERASE: begin
                exe_erase = 1'b1;
                if (hit) begin
                  // [RULE_03] [RULE_04] refused, failure flagged
                  next_s.efail = 1'b1;
                end else begin
                  next_s.efail = 1'b0;
                  next_s.op = NBP_ERASE;
                  next_s.cnt = 12'(PE_BUSY_CYC);
                  next_s.busy_flag_op = 1'b1;
                  next_s.pf_valid = 1'b0;
                end
              end
              `NBP_OP_PAGE_READ: begin
                exe_load = 1'b1;
                next_s.op = NBP_LOAD;
                next_s.busy_flag_op = 1'b1;
                next_s.fast = fast_ok;
                next_s.pf_row = row;
                next_s.pf_valid = 1'b0;
                // [RULE_12] [RULE_13] shortened only for the prefetched page
                next_s.cnt = fast_ok ? 12'(ATC_FAST_CYC) : 12'(ATC_NORMAL_CYC);
              end
              default: next_s.op = s.op;
            endcase
          end
        end
      endcase
    end

    // Busy countdown; a finished load starts the background prefetch
    if (s.op != NBP_IDLE) begin
      if (s.cnt == 12'h001) begin
        next_s.op = NBP_IDLE;
        next_s.busy_flag_op = 1'b0;
        next_s.fast = 1'b0;
        // [RULE_11] next page loads while the host reads this one
        if (s.op == NBP_LOAD && anp) begin
          next_s.pf_valid = 1'b1;
          next_s.pf_row = s.pf_row + 16'h0001;
        end
      end else begin
        next_s.cnt = s.cnt - 12'h001;
      end
    end
    if (!anp) begin
      next_s.pf_valid = 1'b0;
    end

    // [RULE_19] snapshot for feature reads
    next_s.snap.lock = next_s.lock;
    next_s.snap.frz = 8'h00;
    next_s.snap.frz[`NBP_FRZ_BIT] = next_s.frz;
    next_s.snap.cfg = next_s.cfg;
    next_s.snap.stat = 8'h00;
    next_s.snap.stat[`NBP_ST_BUSY] = next_s.busy_flag_op;
    next_s.snap.stat[`NBP_ST_EFAIL] = next_s.efail;
    next_s.snap.stat[`NBP_ST_PFAIL] = next_s.pfail;
  end

  // [RULE_01] [RULE_18] power-up values
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  // All status outputs are register fields
  assign o_busy_flag_op = s.busy_flag_op;
  assign o_prog_fail = s.pfail;
  assign o_erase_fail = s.efail;
  assign o_fast_load = s.fast;
  assign o_block_lock = s.lock;
  assign o_protect_freeze = s.frz;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  power_up_a: assert property (disable iff (1'b0) // [RULE_01] [RULE_18]
    $fell(i_rst) |-> s.lock == `NBP_LK_RST && s.cfg[`NBP_CFG_ECC] && !s.frz)
    else $error("power-up protection or option values wrong");
  guard_set_a: assert property ( // [RULE_02]
    guard |=> ((s.lock & ~$past(s.lock)) & `NBP_LK_GUARD_MASK) == 8'h00)
    else $error("guarded protection bit was set");
  lane_guard_a: assert property ( // [RULE_06]
    s.cfg[`NBP_CFG_FOUR_LANE] && ev && b.idx == 2'h2 && s.opc == `NBP_OP_SET_FEAT
    && s.fa == `NBP_FA_BLOCK_LOCK && !s.frz |=> s.lock == ($past(b.data) & `NBP_LK_WMASK))
    else $error("pin guard active in four-lane setting");
  locked_idle_a: assert property ( // [RULE_03]
    (exe_prog || exe_erase) && hit |=> !s.busy_flag_op && s.op == NBP_IDLE)
    else $error("locked operation started");
  erase_fail_a: assert property ( // [RULE_04]
    exe_erase && hit |=> s.efail ##1 s.efail || ev)
    else $error("erase failure not flagged");
  prog_fail_a: assert property ( // [RULE_05]
    exe_prog && hit |=> s.pfail)
    else $error("program failure not flagged");
  full_lock_a: assert property ( // [RULE_07]
    (exe_prog || exe_erase) && s.lock[`NBP_LK_SEL_2:`NBP_LK_SEL_0] == 3'h7 |-> hit)
    else $error("all-locked code did not lock row");
  freeze_hold_a: assert property ( // [RULE_09] [RULE_10]
    s.frz |=> s.frz && $stable(s.lock))
    else $error("frozen protection changed");
  fast_time_a: assert property ( // [RULE_12]
    exe_load && fast_ok |=> s.cnt == 12'(ATC_FAST_CYC) && s.fast && s.busy_flag_op)
    else $error("prefetched page not shortened");
  slow_time_a: assert property ( // [RULE_13]
    exe_load && !fast_ok |=> s.cnt == 12'(ATC_NORMAL_CYC) && !s.fast)
    else $error("other page not given normal time");
  prefetch_a: assert property ( // [RULE_11]
    s.op == NBP_LOAD && s.cnt == 12'h001 && anp |=> s.pf_valid && s.pf_row == $past(s.pf_row) + 16'h0001)
    else $error("next page not prefetched");
  anp_gate_a: assert property ( // [RULE_14]
    !anp |=> !s.pf_valid)
    else $error("prefetch kept without plain read and correction");

  locked_erase_c: cover property (exe_erase && hit);
  fast_load_c: cover property (exe_load && fast_ok);
  freeze_set_c: cover property ($rose(s.frz));
  guard_refuse_c: cover property (guard && ev && b.idx == 2'h2 && s.fa == `NBP_FA_BLOCK_LOCK);

endmodule
`default_nettype wire

// ### inc/nbp_regs.svh
/*
  Register offsets, field positions, reset values, opcodes and timing
  figures of the block-protection and feature-option logic.
  Assumes a core clock of 100 MHz; all busy counts derive from CLK_PERIOD_NS.
*/
`ifndef NBP_REGS_SVH
`define NBP_REGS_SVH

// Opcodes seen on the serial link
`define NBP_OP_GET_FEAT 8'h0f
`define NBP_OP_SET_FEAT 8'h1f
`define NBP_OP_PROG_EXEC 8'h10
`define NBP_OP_BLK_ERASE 8'hd8
`define NBP_OP_PAGE_READ 8'h13
`define NBP_OP_DTR_RD 8'hed
`define NBP_OP_DTR_RD_4B 8'hee

// Feature addresses
`define NBP_FA_LOCKDOWN 8'h60
`define NBP_FA_BLOCK_LOCK 8'ha0
`define NBP_FA_CONFIG 8'hb0
`define NBP_FA_STATUS 8'hc0

// block_lock fields
`define NBP_LK_PIN_LOCK 7
`define NBP_LK_SEL_2 5
`define NBP_LK_SEL_0 3
`define NBP_LK_FLIP 2
`define NBP_LK_COMPL 1
`define NBP_LK_WMASK 8'hbe
`define NBP_LK_GUARD_MASK 8'h3e
`define NBP_LK_RST 8'h38

// lockdown_control, config and status fields
`define NBP_FRZ_BIT 0
`define NBP_CFG_FOUR_LANE 0
`define NBP_CFG_PLAIN_READ 1
`define NBP_CFG_AUTO_NEXT 2
`define NBP_CFG_TRAIN 3
`define NBP_CFG_ECC 4
`define NBP_CFG_WMASK 8'h1f
`define NBP_CFG_RST 8'h12
`define NBP_ST_BUSY 0
`define NBP_ST_EFAIL 2
`define NBP_ST_PFAIL 3

// Row ranges
`define NBP_ROW_TOP 17'h10000
`define NBP_FRAC_BASE 17'h00400
`define NBP_BLOCK0_LAST 16'h003f

// Training pattern window, in link clocks after the opcode
`define NBP_TRAIN_PAT 8'h34
`define NBP_TRAIN_START 4'h6
`define NBP_TRAIN_START_4B 4'h8
`define NBP_TRAIN_LEN 4'h4

// Timing
`define NBP_CLK_PERIOD_NS 10
`define NBP_ATC_NORMAL_NS 40000
`define NBP_ATC_FAST_NS 10000
`define NBP_PE_BUSY_NS 30000
`define NBP_ATC_NORMAL_CYC ((`NBP_ATC_NORMAL_NS + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)
`define NBP_ATC_FAST_CYC ((`NBP_ATC_FAST_NS + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)
`define NBP_PE_BUSY_CYC ((`NBP_PE_BUSY_NS + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)

`endif

// ### inc/nbp_pkg.sv
/*
  Types shared by the link receiver and the protection core.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nbp_pkg;

  // One received byte and its position in the frame (3 = fourth and later)
  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] data;
  } nbp_byte_t;

  // Feature snapshot offered to the link for reads
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] frz;
    logic [7:0] cfg;
    logic [7:0] stat;
  } nbp_feat_t;

  typedef enum logic [1:0] {NBP_IDLE, NBP_LOAD, NBP_PROG, NBP_ERASE} nbp_op_t;

  // Link state cleared at every frame end
  typedef struct packed {
    logic [2:0] bits;
    logic [6:0] shreg;
    logic [1:0] idx;
    logic opc_get;
    logic quad;
    logic quad_4b;
    logic [3:0] qcnt;
    nbp_feat_t mirror;
    logic [7:0] obyte;
    logic so;
    logic so_oe;
    logic [3:0] dq_rise;
    logic [3:0] dq_fall;
    logic dq_oe;
  } nbp_frame_t;

  // Link state that survives frames
  typedef struct packed {
    logic tog;
    nbp_byte_t buf0;
    nbp_byte_t buf1;
  } nbp_xfer_t;

  // Core state
  typedef struct packed {
    logic [2:0] tsync;
    logic seen;
    logic [2:0] wp_sync;
    logic wp_n;
    logic [7:0] opc;
    logic [7:0] fa;
    logic [7:0] row_hi;
    logic [7:0] lock;
    logic frz;
    logic [7:0] cfg;
    nbp_op_t op;
    logic [11:0] cnt;
    logic busy_flag_op;
    logic pfail;
    logic efail;
    logic fast;
    logic pf_valid;
    logic [15:0] pf_row;
    nbp_feat_t snap;
  } nbp_core_t;

endpackage

// ### core/nbp_link_rx.sv
/*
  Serial link front end on the link clock: deframes bytes, answers feature
  reads and drives the training pattern of quad DTR reads.
  Assumes SPI mode 0, a link clock that only runs inside frames, and a
  DDR output cell outside that merges the rise and fall lane values.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nbp_regs.svh"

module nbp_link_rx (
  input wire logic i_sck,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire nbp_pkg::nbp_feat_t i_snap,
  output logic o_so,
  output logic o_so_oe,
  output logic [3:0] o_dq_rise,
  output logic [3:0] o_dq_fall,
  output logic o_dq_oe,
  output logic o_tog,
  output nbp_pkg::nbp_byte_t o_buf0,
  output nbp_pkg::nbp_byte_t o_buf1
);
  import nbp_pkg::*;

  localparam logic [7:0] TRAIN_PAT = `NBP_TRAIN_PAT;

  nbp_frame_t f, next_f;
  nbp_xfer_t x, next_x;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [3:0] win_start;
  logic [1:0] win_j;

  function automatic logic [7:0] feat_pick(input nbp_feat_t m, input logic [7:0] a);
    case (a)
      `NBP_FA_BLOCK_LOCK: feat_pick = m.lock;
      `NBP_FA_LOCKDOWN: feat_pick = m.frz;
      `NBP_FA_CONFIG: feat_pick = m.cfg;
      `NBP_FA_STATUS: feat_pick = m.stat;
      default: feat_pick = 8'h00;
    endcase
  endfunction

  // Next link state
  always_comb begin
    next_f = f;
    next_x = x;
    rx_byte = {f.shreg, i_si};
    rd_byte = feat_pick(f.mirror, rx_byte);
    win_start = f.quad_4b ? `NBP_TRAIN_START_4B : `NBP_TRAIN_START;
    win_j = 2'(f.qcnt - win_start);
    next_f.dq_oe = 1'b0;
    next_f.dq_rise = 4'h0;
    next_f.dq_fall = 4'h0;
    if (f.quad) begin
      if (f.qcnt != 4'hf) begin
        next_f.qcnt = f.qcnt + 4'h1;
      end
      // [RULE_15] [RULE_16] pattern in window
      if (f.mirror.cfg[`NBP_CFG_TRAIN] && f.qcnt >= win_start
          && f.qcnt < win_start + `NBP_TRAIN_LEN) begin
        next_f.dq_oe = 1'b1;
        next_f.dq_rise = {4{TRAIN_PAT[{~win_j, 1'b1}]}};
        next_f.dq_fall = {4{TRAIN_PAT[{~win_j, 1'b0}]}};
      end
    end else begin
      next_f.bits = f.bits + 3'h1;
      next_f.shreg = rx_byte[6:0];
      if (f.so_oe) begin
        next_f.so = f.obyte[7];
        next_f.obyte = {f.obyte[6:0], f.obyte[7]};
      end
      if (f.bits == 3'h7) begin
        // New byte goes to the buffer named by the new toggle value
        next_x.tog = ~x.tog;
        if (x.tog) begin
          next_x.buf0 = '{idx: f.idx, data: rx_byte};
        end else begin
          next_x.buf1 = '{idx: f.idx, data: rx_byte};
        end
        if (f.idx != 2'h3) begin
          next_f.idx = f.idx + 2'h1;
        end
        if (f.idx == 2'h0) begin
          // Snapshot is quiet here as long as frames keep the gap
          next_f.mirror = i_snap;
          next_f.opc_get = rx_byte == `NBP_OP_GET_FEAT;
          next_f.quad = rx_byte == `NBP_OP_DTR_RD || rx_byte == `NBP_OP_DTR_RD_4B;
          next_f.quad_4b = rx_byte == `NBP_OP_DTR_RD_4B;
        end
        // [RULE_19] feature read answer
        if (f.idx == 2'h1 && f.opc_get) begin
          next_f.so_oe = 1'b1;
          next_f.so = rd_byte[7];
          next_f.obyte = {rd_byte[6:0], rd_byte[7]};
        end
      end
    end
  end

  // Frame state ends with the frame's own select
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Handoff state survives frames so the core never misses a toggle
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      x <= '0;
    end else begin
      x <= next_x;
    end
  end

  assign o_so = f.so;
  assign o_so_oe = f.so_oe;
  assign o_dq_rise = f.dq_rise;
  assign o_dq_fall = f.dq_fall;
  assign o_dq_oe = f.dq_oe;
  assign o_tog = x.tog;
  assign o_buf0 = x.buf0;
  assign o_buf1 = x.buf1;

  train_off_a: assert property (@(posedge i_sck) disable iff (i_cs_n) // [RULE_16]
    !f.mirror.cfg[`NBP_CFG_TRAIN] |=> !f.dq_oe)
    else $error("training pattern driven while disabled");
  train_len_a: assert property (@(posedge i_sck) disable iff (i_cs_n) // [RULE_15]
    $rose(f.dq_oe) |-> f.dq_rise == 4'h0 ##1 f.dq_oe && f.dq_rise == 4'hf
    ##1 f.dq_oe && f.dq_fall == 4'hf ##1 f.dq_oe ##1 !f.dq_oe)
    else $error("training window not four clocks of the pattern");
  train_seen_c: cover property (@(posedge i_sck) disable iff (i_cs_n) $rose(f.dq_oe));

endmodule
`default_nettype wire

// ### verification/nbp_host_model.sv
/*
  Host controller model: frames commands on the serial link and records
  serial read data and the training pattern seen during a frame.
  Assumes SPI mode 0 and a 6 ns link clock that stands still between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module nbp_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic [3:0] i_dq_rise,
  input wire logic [3:0] i_dq_fall,
  input wire logic i_dq_oe
);
  logic [7:0] rx;
  logic [7:0] pat;
  int nq;

  // Idle link at time zero
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    rx = 8'h00;
    pat = 8'h00;
    nq = 0;
  end

  task automatic frame(input logic [31:0] d, input int nb, input int nx);
    nq = 0;
    pat = 8'h00;
    o_cs_n = 1'b0;
    #4;
    for (int i = 0; i < nb * 8 + nx; i++) begin
      // Past the bytes the line toggles, so stale data never looks valid
      o_si = (i < nb * 8) ? d[nb * 8 - 1 - i] : ~o_si;
      #3 o_sck = 1'b1;
      #1 rx = {rx[6:0], i_so};
      if (i_dq_oe) begin
        pat = {pat[5:0], &i_dq_rise, &i_dq_fall};
        nq++;
      end
      #2 o_sck = 1'b0;
    end
    #4 o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule

`default_nettype wire

// ### verification/tb.sv
/*
  Testbench: feature, array and training frames through the host model,
  with expected values from the protection and option rules.
  Assumes the core and link front end of nbp_block_protect.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import nbp_pkg::*;
  logic clk, rst, wp_n, sck, cs_n, si, so, so_oe, dq_oe;
  logic busy, pfail, efail, fast, frz;
  logic [3:0] dqr, dqf;
  logic [7:0] lock;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_oe = 0;
  logic [7:0] codes [5] = '{8'h08, 8'h14, 8'h32, 8'h2e, 8'h2a};
  logic [15:0] rin [5] = '{16'hfc00, 16'h07ff, 16'h003f, 16'h4000, 16'hbfff};
  logic [15:0] rout [5] = '{16'hfbff, 16'h0800, 16'h0040, 16'h3fff, 16'hc000};

  // Short counts keep the run brief
  nbp_block_protect #(.ATC_NORMAL_CYC(40), .ATC_FAST_CYC(10), .PE_BUSY_CYC(30)) uut (
    .i_ref_clk(clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_dq_rise(dqr), .o_dq_fall(dqf),
    .o_dq_oe(dq_oe), .o_busy_flag_op(busy), .o_prog_fail(pfail),
    .o_erase_fail(efail), .o_fast_load(fast), .o_block_lock(lock),
    .o_protect_freeze(frz));

  nbp_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so),
    .i_dq_rise(dqr), .i_dq_fall(dqf), .i_dq_oe(dq_oe));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well above the fewer than 2000 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      finish_test();
    end
  end

  // Count link clocks that carry feature read data
  always @(negedge sck) begin
    if (so_oe)
      n_oe <= n_oe + 1;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Gap after each frame so select is seen high between frames
  task automatic fr(input logic [31:0] d, input int nb, input int nx);
    @(negedge clk);
    host.frame(d, nb, nx);
    w(2);
  endtask

  task automatic sf(input logic [7:0] a, input logic [7:0] d);
    fr(32'({8'h1f, a, d}), 3, 0);
    w(8);
  endtask

  task automatic gf(input logic [7:0] a, input logic [7:0] exp);
    n_oe = 0;
    fr(32'({8'h0f, a}), 2, 7);
    chk(host.rx, exp);
    chk(8'(n_oe), 8'h08);
    w(8);
  endtask

  task automatic wt();
    for (int k = 0; k < 100 && busy; k++)
      w(1);
    chk({7'h00, busy}, 8'h00);
  endtask

  task automatic pr(input logic [15:0] row, input logic f);
    fr({8'h13, 8'h00, row}, 4, 0);
    w(5);
    chk({6'h00, busy, fast}, {6'h00, 1'b1, f});
    wt();
  endtask

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk(lock, 8'h38);
    chk({4'h0, frz, busy, pfail, efail}, 8'h00);
    gf(8'hb0, 8'h12);
    gf(8'ha0, 8'h38);
    fr({8'hd8, 8'h00, 16'hffc0}, 4, 0);
    w(8);
    chk({6'h00, busy, efail}, 8'h01);
    gf(8'hc0, 8'h04);
    // Five lock codes: a row inside is refused, one just outside runs
    for (int k = 0; k < 5; k++) begin
      sf(8'ha0, codes[k]);
      chk(lock, codes[k]);
      fr({8'h10, 8'h00, rin[k]}, 4, 0);
      w(8);
      chk({6'h00, busy, pfail}, 8'h01);
      fr({8'h10, 8'h00, rout[k]}, 4, 0);
      w(5);
      chk({6'h00, busy, pfail}, 8'h02);
      wt();
    end
    sf(8'ha0, 8'h80);
    wp_n = 1'b0;
    w(5);
    sf(8'ha0, 8'hbe);
    chk(lock, 8'h80);
    sf(8'hb0, 8'h13);
    sf(8'ha0, 8'hbe);
    chk(lock, 8'hbe);
    sf(8'hb0, 8'h12);
    sf(8'ha0, 8'h80);
    chk(lock, 8'h80);
    wp_n = 1'b1;
    sf(8'hb0, 8'h16);
    pr(16'h0010, 1'b0);
    pr(16'h0011, 1'b1);
    pr(16'h0030, 1'b0);
    sf(8'hb0, 8'h06);
    pr(16'h0040, 1'b0);
    pr(16'h0041, 1'b0);
    sf(8'hb0, 8'h1a);
    fr(32'h0000_00ed, 1, 12);
    chk(host.pat, 8'h34);
    chk(8'(host.nq), 8'h04);
    fr(32'h0000_00ee, 1, 14);
    chk(host.pat, 8'h34);
    chk(8'(host.nq), 8'h04);
    sf(8'hb0, 8'h12);
    fr(32'h0000_00ed, 1, 12);
    chk(8'(host.nq), 8'h00);
    sf(8'ha0, 8'h00);
    sf(8'h60, 8'h01);
    chk({7'h00, frz}, 8'h01);
    sf(8'ha0, 8'h38);
    chk(lock, 8'h00);
    sf(8'h60, 8'h00);
    gf(8'h60, 8'h01);
    finish_test();
  end
endmodule

`default_nettype wire
